/* File: rtl/adc_conversion_control.sv */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - A conversion ends sixteen converter clocks after it starts.
// - A control register write starts a conversion at next converter tick.
// - Waiting for that tick can stretch a conversion to seventeen clocks.
// - Continuous mode overwrites the result after every conversion.
// - Continuous runs until its bit clears; otherwise one conversion per start.
// - Without interrupts the done flag sets and holds until result read.
// - With interrupts enabled each conversion end raises the interrupt.
// - With interrupts enabled the done flag stays zero.
// - The selected channel pin is forced to input for the converter.
// - Port data or direction writes do not affect the selected pin.
// - Selected pin reads zero with direction 0, latch with direction 1.
// - Unselected channel pins stay ordinary port pins.
// - Codes saturate at FF above high and 00 below low reference.
// - Results are eight bits, monotonic, with no missing codes.
// - The multiplexer routes at most one of fifteen channels to the core.
// - Stop mode aborts any conversion; continuous conversions resume on exit.
// - Channel code all ones powers the converter off; reset loads it.
// - Prescale divides by 1, 2, 4, 8, or 16 when top bit set.
// - Clock source bit picks bus clock at 1, external at 0.
// - Result read or control write clears a pending interrupt.
module adc_conversion_control
   import adc_ctrl_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   input  wire logic        i_external_oscillator_clock,
   input  wire logic        i_comp_above,
   input  wire logic        i_stop_mode,
   input  wire logic [14:0] i_pin_level,
   input  wire logic [14:0] i_port_latch,
   input  wire logic [14:0] i_port_dir,
   output logic [14:0]      o_port_read,
   output logic [14:0]      o_pin_out,
   output logic [14:0]      o_pin_oe,
   output logic [14:0]      o_analog_select,
   output logic [7:0]       o_dac_code,
   output logic             o_converter_power,
   output logic             o_sample,
   output logic             o_conversion_irq
);

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        arready;
      logic        aw_full;
      logic        w_full;
      logic [7:0]  aw_addr;
      logic [7:0]  w_data;
      logic        w_en;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
      logic        ien;
      logic        cont;
      logic [4:0]  chan;
      logic        done_flag;
      logic        irq;
      logic        src_sel;
      logic [2:0]  presc;
      logic [7:0]  result;
      logic        osc_s1;
      logic        osc_s2;
      logic        osc_prev;
      logic        comp_s1;
      logic        comp_s2;
      logic [14:0] pin_s1;
      logic [14:0] pin_s2;
      logic [3:0]  div_cnt;
      logic        tick;
      logic        start_pend;
      logic        busy;
      logic [3:0]  cnt;
      logic [7:0]  sar;
      logic [7:0]  dac;
      logic        stop_prev;
      logic        power;
      logic        sample;
      logic [14:0] port_read;
      logic [14:0] pin_out;
      logic [14:0] pin_oe;
      logic [14:0] ana_sel;
   } state_s;

   localparam state_s RESET_STATE = '{
      awready : 1'b1,
      wready  : 1'b1,
      arready : 1'b1,
      chan    : CHAN_RESET,
      presc   : PRESC_RESET,
      src_sel : SRC_RESET,
      default : '0
   };

   state_s state;
   state_s next_state;

   // Ratio minus one for the converter clock prescaler.
   function automatic logic [3:0] div_limit(input logic [2:0] code);
      logic [3:0] lim;
      lim = 4'hF;
      if (!code[2]) begin
         lim = 4'((5'h01 << code[1:0]) - 5'h01);
      end
      return lim;
   endfunction

   // One-hot pin select; power off and reference codes select no pin.
   function automatic logic [14:0] chan_onehot(input logic [4:0] ch);
      logic [14:0] sel;
      sel = 15'h0000;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (ch == 5'(i)) begin
            sel[i] = 1'b1;
         end
      end
      return sel;
   endfunction

   // Trial bit for the successive approximation step at a tick count.
   function automatic logic [7:0] trial_mask(input logic [3:0] c);
      logic [7:0] m;
      m = 8'h00;
      if (c >= SAR_FIRST_TICK && c <= SAR_LAST_TICK) begin
         m = 8'h80 >> (c - SAR_FIRST_TICK);
      end
      return m;
   endfunction

   always_comb begin
      logic       aw_take;
      logic       w_take;
      logic       wr_go;
      logic       rd_go;
      logic       src_pulse;
      logic       irq_set;
      logic       irq_clr;
      logic       done_set;
      logic       done_clr;
      logic [7:0] rd_val;
      aw_take   = i_awvalid && state.awready;
      w_take    = i_wvalid && state.wready;
      wr_go     = state.aw_full && state.w_full && !state.bvalid;
      rd_go     = i_arvalid && state.arready;
      src_pulse = state.src_sel ? 1'b1
                : (state.osc_s2 && !state.osc_prev);
      irq_set   = 1'b0;
      irq_clr   = 1'b0;
      done_set  = 1'b0;
      done_clr  = 1'b0;
      rd_val    = 8'h00;
      next_state = state;

      // Input synchronisers.
      next_state.osc_s1   = i_external_oscillator_clock;
      next_state.osc_s2   = state.osc_s1;
      next_state.osc_prev = state.osc_s2;
      next_state.comp_s1  = i_comp_above;
      next_state.comp_s2  = state.comp_s1;
      next_state.pin_s1   = i_pin_level;
      next_state.pin_s2   = state.pin_s1;
      next_state.stop_prev = i_stop_mode;

      // Converter clock tick from the selected source and prescaler.
      next_state.tick = 1'b0;
      if (src_pulse) begin
         if (state.div_cnt >= div_limit(state.presc)) begin
            next_state.div_cnt = 4'h0;
            next_state.tick    = 1'b1;
         end else begin
            next_state.div_cnt = state.div_cnt + 4'h1;
         end
      end

      // Conversion sequencer, advanced once per converter tick.
      next_state.sample = 1'b0;
      if (i_stop_mode) begin
         next_state.busy = 1'b0;
      end else if (state.tick && state.power) begin
         if (state.start_pend) begin
            next_state.start_pend = 1'b0;
            next_state.busy       = 1'b1;
            next_state.cnt        = 4'h0;
            next_state.sar        = 8'h00;
            next_state.sample     = 1'b1;
         end else if (state.busy) begin
            if (state.comp_s2) begin
               next_state.sar = state.sar | trial_mask(state.cnt);
            end
            if (state.cnt == CONV_LAST_TICK) begin
               next_state.result = state.sar;
               irq_set  = state.ien;
               done_set = !state.ien;
               next_state.cnt = 4'h0;
               next_state.sar = 8'h00;
               next_state.busy = state.cont;
               next_state.sample = state.cont;
            end else begin
               next_state.cnt = state.cnt + 4'h1;
            end
         end
      end
      if (state.stop_prev && !i_stop_mode && state.cont) begin
         next_state.start_pend = 1'b1;
      end

      // Write channel: address and data are taken in either order.
      if (aw_take) begin
         next_state.aw_full = 1'b1;
         next_state.aw_addr = i_awaddr;
      end
      if (w_take) begin
         next_state.w_full = 1'b1;
         next_state.w_data = i_wdata[7:0];
         next_state.w_en   = i_wstrb[0];
      end
      if (wr_go) begin
         next_state.aw_full = 1'b0;
         next_state.w_full  = 1'b0;
         next_state.bvalid  = 1'b1;
         next_state.bresp   = RESP_OKAY;
         case (state.aw_addr)
            ADDR_CSC: begin
               if (state.w_en) begin
                  next_state.ien  = state.w_data[CSC_IEN_BIT];
                  next_state.cont = state.w_data[CSC_CONT_BIT];
                  next_state.chan = state.w_data[CSC_CHAN_LSB +: 5];
                  next_state.busy = 1'b0;
                  next_state.sample = 1'b0;
                  next_state.start_pend = 1'b1;
                  irq_clr = 1'b1;
               end
            end
            ADDR_CLKSEL: begin
               if (state.w_en) begin
                  next_state.presc = state.w_data[CLK_PRESC_LSB +: 3];
                  next_state.src_sel = state.w_data[CLK_SRC_BIT];
               end
            end
            ADDR_RESULT: begin
               next_state.bresp = RESP_OKAY;
            end
            default: begin
               next_state.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (state.bvalid && i_bready) begin
         next_state.bvalid = 1'b0;
      end
      next_state.awready = !next_state.aw_full && !next_state.bvalid;
      next_state.wready  = !next_state.w_full && !next_state.bvalid;

      // Read channel.
      if (rd_go) begin
         next_state.rvalid  = 1'b1;
         next_state.arready = 1'b0;
         next_state.rresp   = RESP_OKAY;
         case (i_araddr)
            ADDR_CSC: begin
               rd_val[CSC_DONE_BIT] = state.done_flag && !state.ien;
               rd_val[CSC_IEN_BIT]  = state.ien;
               rd_val[CSC_CONT_BIT] = state.cont;
               rd_val[CSC_CHAN_LSB +: 5] = state.chan;
            end
            ADDR_RESULT: begin
               rd_val   = state.result;
               done_clr = 1'b1;
               irq_clr  = 1'b1;
            end
            ADDR_CLKSEL: begin
               rd_val[CLK_PRESC_LSB +: 3] = state.presc;
               rd_val[CLK_SRC_BIT]        = state.src_sel;
            end
            default: begin
               next_state.rresp = RESP_SLVERR;
            end
         endcase
         next_state.rdata = rd_val;
      end
      if (state.rvalid && i_rready) begin
         next_state.rvalid  = 1'b0;
         next_state.arready = 1'b1;
      end

      // Flags: an event in the clearing cycle wins over the clear.
      next_state.irq = (state.irq && !irq_clr) || irq_set;
      next_state.done_flag = ((state.done_flag && !done_clr) || done_set)
                           && !next_state.ien;

      // Power off aborts and drops any queued start.
      next_state.power = (next_state.chan != CHAN_POWER_OFF);
      if (!next_state.power) begin
         next_state.busy       = 1'b0;
         next_state.start_pend = 1'b0;
         next_state.sample     = 1'b0;
      end
      next_state.dac = next_state.sar | trial_mask(next_state.cnt);

      // Port override for the channel the converter has selected.
      next_state.ana_sel = chan_onehot(next_state.chan);
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (next_state.ana_sel[i]) begin
            next_state.pin_oe[i]    = 1'b0;
            next_state.pin_out[i]   = 1'b0;
            next_state.port_read[i] = i_port_dir[i]
                                    && i_port_latch[i];
         end else begin
            next_state.pin_oe[i]    = i_port_dir[i];
            next_state.pin_out[i]   = i_port_latch[i];
            next_state.port_read[i] = i_port_dir[i] ? i_port_latch[i]
                                    : state.pin_s2[i];
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= RESET_STATE;
      end else begin
         state <= next_state;
      end
   end

   assign o_awready         = state.awready;
   assign o_wready          = state.wready;
   assign o_arready         = state.arready;
   assign o_bvalid          = state.bvalid;
   assign o_bresp           = state.bresp;
   assign o_rvalid          = state.rvalid;
   assign o_rdata           = {24'h000000, state.rdata};
   assign o_rresp           = state.rresp;
   assign o_port_read       = state.port_read;
   assign o_pin_out         = state.pin_out;
   assign o_pin_oe          = state.pin_oe;
   assign o_analog_select   = state.ana_sel;
   assign o_dac_code        = state.dac;
   assign o_converter_power = state.power;
   assign o_sample          = state.sample;
   assign o_conversion_irq  = state.irq;

endmodule

/* File: shared/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

   // Register byte addresses on the AXI4-Lite bus.
   localparam logic [7:0] ADDR_CSC    = 8'h38;
   localparam logic [7:0] ADDR_RESULT = 8'h3C;
   localparam logic [7:0] ADDR_CLKSEL = 8'h40;

   // Status and control register layout.
   localparam int CSC_DONE_BIT = 7;
   localparam int CSC_IEN_BIT  = 6;
   localparam int CSC_CONT_BIT = 5;
   localparam int CSC_CHAN_LSB = 0;

   // Clock select register layout.
   localparam int CLK_PRESC_LSB = 5;
   localparam int CLK_SRC_BIT   = 4;

   // Reset values.
   localparam logic [4:0] CHAN_RESET  = 5'h1F;
   localparam logic [2:0] PRESC_RESET = 3'h0;
   localparam logic       SRC_RESET   = 1'b0;

   // Channel codes.
   localparam logic [4:0] CHAN_POWER_OFF = 5'h1F;
   localparam int         NUM_CHAN       = 15;

   // Conversion timing in converter clock ticks.
   localparam logic [3:0] CONV_LAST_TICK = 4'hF;
   localparam logic [3:0] SAR_FIRST_TICK = 4'h4;
   localparam logic [3:0] SAR_LAST_TICK  = 4'hB;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: dv/adc_conversion_control_properties.sv */
`timescale 1ns/1ps
module adc_conversion_control_properties (
   input wire logic        i_core_clk,
   input wire logic        i_rst,
   input wire logic        i_awvalid,
   input wire logic        i_wvalid,
   input wire logic        i_arvalid,
   input wire logic        i_stop_mode,
   input wire logic [14:0] i_port_latch,
   input wire logic [14:0] i_port_dir,
   input wire logic        o_bvalid,
   input wire logic        o_rvalid,
   input wire logic [14:0] o_port_read,
   input wire logic [14:0] o_pin_oe,
   input wire logic [14:0] o_analog_select,
   input wire logic        o_converter_power,
   input wire logic        o_sample,
   input wire logic        o_conversion_irq
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   AST_ONE_CHAN: assert property ($onehot0(o_analog_select))
      else $error("more than one channel selected");
   AST_POWER_OFF: assert property (!o_converter_power |->
      o_analog_select == 15'h0000 && !o_sample)
      else $error("powered down converter still active");
   AST_PIN_INPUT: assert property (
      (o_analog_select & o_pin_oe) == 15'h0000)
      else $error("selected pin is driven");
   AST_SEL_READ: assert property (((o_port_read ^
      ($past(i_port_dir) & $past(i_port_latch))) & o_analog_select)
      == 15'h0000)
      else $error("selected pin read value wrong");
   AST_UNSEL_DRIVE: assert property (
      !$past(i_rst) && $stable(o_analog_select) |->
      o_pin_oe == ($past(i_port_dir) & ~o_analog_select))
      else $error("pin drive enable wrong");
   AST_SAMPLE_PULSE: assert property (o_sample |=> !o_sample)
      else $error("sample pulse too long");
   AST_STOP_HOLD: assert property (
      $past(i_stop_mode) && i_stop_mode |->
      !o_sample && !$rose(o_conversion_irq))
      else $error("conversion activity in stop mode");
   AST_IRQ_HOLD: assert property (
      o_conversion_irq && !i_arvalid && !i_awvalid && !i_wvalid &&
      !o_rvalid && !o_bvalid && !$past(o_rvalid) && !$past(o_bvalid) &&
      !$past(i_awvalid) && !$past(i_wvalid)
      |=> o_conversion_irq)
      else $error("interrupt dropped without bus access");
endmodule

/* File: dv/adc_analog_model.sv */
`timescale 1ns/1ps
module adc_analog_model (
   input  wire logic        i_core_clk,
   input  wire logic [7:0]  i_dac_code,
   input  wire logic [14:0] i_analog_select,
   input  wire logic [14:0] i_pin_out,
   input  wire logic [14:0] i_pin_oe,
   output logic             o_comp_above,
   output logic [14:0]      o_pin_level
);
   logic [8:0]  level_x2;
   logic [14:0] float_pattern = 15'h2AAA;

   // Each channel sits half a step above code 8'h11*ch+8'h07.
   always_comb begin
      level_x2 = 9'h001;
      for (int ch = 0; ch < 15; ch++) begin
         if (i_analog_select[ch]) begin
            level_x2 = 9'((8'h11 * ch + 8'h07) * 2 + 1);
         end
      end
   end

   assign o_comp_above = level_x2 > {i_dac_code, 1'b0};

   // Undriven pads toggle every cycle so no stale level is seen.
   always_ff @(posedge i_core_clk) begin
      float_pattern <= ~float_pattern;
   end
   assign o_pin_level = (i_pin_out & i_pin_oe) | (float_pattern & ~i_pin_oe);
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench
   import adc_ctrl_pkg::*;
;
   logic        clk, rst, awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd;
   logic        xclk, cmp, stop, pwr, smp, irq;
   logic [7:0]  awa, ara, dac;
   logic [31:0] wd, rdat;
   logic [3:0]  ws;
   logic [1:0]  bres, rres;
   logic [14:0] lvl, ltc, dir, prd, pout, poe, sel;
   int          fail_count, checks_done, g, xc;
   logic [2:0]  pc [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   int          pd [6] = '{1, 2, 4, 8, 16, 16};

   always #25 clk = ~clk;
   always @(posedge clk) begin
      xc <= (xc == 2) ? 0 : xc + 1;
      if (xc == 2) xclk <= ~xclk;
   end

   adc_conversion_control dut (
      .i_core_clk(clk), .i_rst(rst), .i_awvalid(awv), .o_awready(awr),
      .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd),
      .i_wstrb(ws), .o_bvalid(bv), .i_bready(brd), .o_bresp(bres),
      .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
      .i_rready(rrd), .o_rdata(rdat), .o_rresp(rres),
      .i_external_oscillator_clock(xclk), .i_comp_above(cmp),
      .i_stop_mode(stop), .i_pin_level(lvl), .i_port_latch(ltc),
      .i_port_dir(dir), .o_port_read(prd), .o_pin_out(pout),
      .o_pin_oe(poe), .o_analog_select(sel), .o_dac_code(dac),
      .o_converter_power(pwr), .o_sample(smp), .o_conversion_irq(irq));
   adc_analog_model model (.i_core_clk(clk), .i_dac_code(dac),
      .i_analog_select(sel), .i_pin_out(pout), .i_pin_oe(poe),
      .o_comp_above(cmp), .o_pin_level(lvl));

   task automatic check(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic hang(input string n);
      fail_count++;
      $display("mismatch %s expected response seen timeout", n);
      summarize();
   endtask
   task automatic bus_wr(input logic [7:0] a, d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= {24'h000000, d};
      ws <= 4'hF;
      brd <= 1'b1;
      for (n = 0; n < 99 && bv !== 1'b1; n++) begin
         @(posedge clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wrd === 1'b1) wv <= 1'b0;
      end
      if (n == 99) hang("bresp");
      brd <= 1'b0;
      check("bresp", bres, er);
   endtask
   task automatic bus_rd(input logic [7:0] a, e, input logic [1:0] er);
      int n;
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rrd <= 1'b1;
      for (n = 0; n < 99 && rv !== 1'b1; n++) begin
         @(posedge clk);
         if (arr === 1'b1) arv <= 1'b0;
      end
      if (n == 99) hang("rresp");
      rrd <= 1'b0;
      check("rdata", rdat, {24'h000000, e});
      check("rresp", rres, er);
   endtask
   task automatic gap(output int c);
      int n;
      for (n = 0; n < 3000 && smp !== 1'b1; n++) @(posedge clk);
      if (n == 3000) hang("sample");
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (smp !== 1'b1 && c < 3000);
      if (c == 3000) hang("sample");
   endtask
   task automatic count(input int cy, output int c);
      c = 0;
      repeat (cy) begin
         @(posedge clk);
         if (smp === 1'b1) c++;
      end
   endtask
   task automatic wait_irq();
      int n;
      for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
      if (n == 3000) hang("irq");
   endtask

   initial begin
      {clk, awv, wv, brd, arv, rrd, stop, xclk, xc} = '0;
      {awa, ara, wd, ws} = '0;
      rst = 1'b1;
      ltc = 15'h7FFF;
      dir = 15'h0028;
      fail_count = 0;
      checks_done = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      bus_rd(ADDR_CSC, 8'h1F, RESP_OKAY);
      check("power", pwr, 1'b0);
      bus_rd(ADDR_CLKSEL, 8'h00, RESP_OKAY);
      bus_rd(ADDR_RESULT, 8'h00, RESP_OKAY);
      bus_rd(8'h44, 8'h00, RESP_SLVERR);
      bus_wr(8'h44, 8'h12, RESP_SLVERR);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         bus_wr(ADDR_CLKSEL, {pc[i], 5'h10}, RESP_OKAY);
         bus_wr(ADDR_CSC, 8'h20, RESP_OKAY);
         gap(g);
         gap(g);
         check("gap", g, 16 * pd[i]);
      end
      bus_wr(ADDR_CLKSEL, 8'h00, RESP_OKAY);
      gap(g);
      gap(g);
      check("gap", g, 96);
      $display("test clock done");
      bus_wr(ADDR_CLKSEL, 8'h50, RESP_OKAY);
      bus_wr(ADDR_CSC, 8'h43, RESP_OKAY);
      wait_irq();
      check("port_read", prd[3], 1'b1);
      check("pin_oe", poe, 15'h0020);
      check("pin_out", pout[5], 1'b1);
      check("pin_out", pout, 15'h7FF7);
      check("select", sel, 15'h0008);
      bus_rd(ADDR_CSC, 8'h43, RESP_OKAY);
      check("irq", irq, 1'b1);
      bus_rd(ADDR_RESULT, 8'h3A, RESP_OKAY);
      repeat (2) @(posedge clk);
      check("irq", irq, 1'b0);
      dir <= 15'h0020;
      count(200, g);
      check("samples", g, 0);
      check("port_read", prd[3], 1'b0);
      $display("test interrupt done");
      bus_wr(ADDR_CSC, 8'h25, RESP_OKAY);
      gap(g);
      gap(g);
      repeat (4) @(posedge clk);
      bus_rd(ADDR_CSC, 8'hA5, RESP_OKAY);
      bus_rd(ADDR_RESULT, 8'h5C, RESP_OKAY);
      bus_rd(ADDR_CSC, 8'h25, RESP_OKAY);
      stop <= 1'b1;
      @(posedge clk);
      count(300, g);
      check("samples", g, 0);
      stop <= 1'b0;
      gap(g);
      gap(g);
      check("gap", g, 64);
      bus_rd(ADDR_RESULT, 8'h5C, RESP_OKAY);
      $display("test stop done");
      bus_wr(ADDR_CSC, 8'h65, RESP_OKAY);
      wait_irq();
      bus_wr(ADDR_CSC, 8'h65, RESP_OKAY);
      repeat (2) @(posedge clk);
      check("irq", irq, 1'b0);
      bus_wr(ADDR_CSC, 8'h1F, RESP_OKAY);
      repeat (2) @(posedge clk);
      check("power", pwr, 1'b0);
      $display("test power down done");
      summarize();
   end
endmodule

bind adc_conversion_control adc_conversion_control_properties props (
   .i_core_clk, .i_rst, .i_awvalid, .i_wvalid, .i_arvalid, .i_stop_mode,
   .i_port_latch, .i_port_dir, .o_bvalid, .o_rvalid, .o_port_read,
   .o_pin_oe, .o_analog_select, .o_converter_power, .o_sample,
   .o_conversion_irq);
